// File: rtl/ec_rx_error_checker.sv
// Purpose: Classifies each received TLP header, drops or forwards it, requests UR completions,
//          tracks outstanding tags and emits at most one error event per cycle.
// Assumes: One parsed header per rx_valid pulse, on clk_sys; app_err from logic on clk_sys.
// Notes:   All verdicts appear one cycle after the header; app reports wait behind TLP errors.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "ec_params.svh"

module ec_rx_error_checker #(
    parameter int NUM_TAGS = 32
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        rx_valid,
    input  wire logic [2:0]  rx_fmt,
    input  wire logic [4:0]  rx_type,
    input  wire logic        rx_poison,
    input  wire logic [15:0] rx_req_id,
    input  wire logic [7:0]  rx_tag,
    input  wire logic [9:0]  rx_length,
    input  wire logic [2:0]  rx_cpl_status,
    input  wire logic        rx_cpl_last,
    input  wire logic        rx_addr_hi_zero,
    input  wire logic        rx_bar_hit,
    input  wire logic        rx_func_exists,
    input  wire logic        rx_msg_known,
    input  wire logic        rx_overflow,
    input  wire logic        rx_malformed,
    input  wire logic        req_issue,
    input  wire logic [7:0]  req_tag,
    input  wire logic        req_to_cfg,
    input  wire logic        req_to_io,
    input  wire logic [2:0]  app_err,
    output logic             app_valid,
    output logic             app_poison,
    output logic             cfg_update,
    output logic             ur_cpl_valid,
    output logic      [15:0] ur_cpl_req_id,
    output logic      [7:0]  ur_cpl_tag,
    output logic             err_valid,
    output ec_pkg::ec_class_e err_class,
    output ec_pkg::ec_cause_e err_cause
);

    // Complete state of the checker.
    typedef struct packed {
        logic                native_ep;
        logic                mem_en;
        logic [15:0]         own_id;
        logic [7:0]          tag_limit;
        logic [NUM_TAGS-1:0] outstand;
        logic [NUM_TAGS-1:0] kind_cfg;
        logic [NUM_TAGS-1:0] kind_small;
        logic [1:0]          app_pend;
        logic [7:0]          nf_count;
        logic [7:0]          fatal_count;
        logic [31:0]         rdata;
        logic                app_valid;
        logic                app_poison;
        logic                cfg_update;
        logic                ur_valid;
        logic [15:0]         ur_req_id;
        logic [7:0]          ur_tag;
        logic                err_valid;
        ec_pkg::ec_class_e   err_class;
        ec_pkg::ec_cause_e   err_cause;
    } ec_state_s;

    ec_state_s st_reg;
    ec_state_s st_next;

    // Header decode, shared by the classifier and the assertions.
    logic is_mem;
    logic is_mem_lock_rd;
    logic is_io;
    logic is_cfg0;
    logic is_cfg1;
    logic is_msg;
    logic is_cpl;
    logic is_cpl_lock;
    logic has_data;
    logic posted;
    logic tag_in_range;
    logic unsupp;
    logic unexp_cpl;
    logic dropped;
    logic deliver;
    logic cpl_clear;

    // Classifies the current header.
    always_comb begin
        is_mem         = (rx_type == `EC_TYPE_MEM) || (rx_type == `EC_TYPE_MEM_LOCK);
        has_data       = rx_fmt[1];
        is_mem_lock_rd = (rx_type == `EC_TYPE_MEM_LOCK) && !has_data;
        is_io          = (rx_type == `EC_TYPE_IO);
        is_cfg0        = (rx_type == `EC_TYPE_CFG0);
        is_cfg1        = (rx_type == `EC_TYPE_CFG1);
        is_msg         = (rx_type[4:3] == `EC_MSG_PREFIX);
        is_cpl         = (rx_type == `EC_TYPE_CPL) || (rx_type == `EC_TYPE_CPL_LOCK);
        is_cpl_lock    = (rx_type == `EC_TYPE_CPL_LOCK);
        posted         = (is_mem && has_data) || is_msg;
        tag_in_range   = (rx_tag < st_reg.tag_limit) && (32'(rx_tag) < NUM_TAGS);
        unsupp         = (is_cfg0 && !rx_func_exists)
                       || (is_msg && !rx_msg_known) || is_cfg1
                       || (is_mem_lock_rd && st_reg.native_ep)
                       || (is_cpl_lock && rx_addr_hi_zero)
                       || ((is_mem || is_io) && !rx_bar_hit)
                       || (is_mem && !st_reg.mem_en)
                       || (is_cfg0 && has_data && rx_poison);
        unexp_cpl      = is_cpl && !unsupp && ((rx_req_id != st_reg.own_id)
                       || !tag_in_range
                       || !st_reg.outstand[rx_tag[$clog2(NUM_TAGS)-1:0]]
                       || (st_reg.kind_small[rx_tag[$clog2(NUM_TAGS)-1:0]]
                           && rx_length != `EC_CPL_SMALL_LEN)
                       || (rx_cpl_status == `EC_CPL_STATUS_CRS
                           && !st_reg.kind_cfg[rx_tag[$clog2(NUM_TAGS)-1:0]]));
        dropped        = rx_overflow || rx_malformed || unsupp || unexp_cpl;
        deliver        = rx_valid && !dropped;
        cpl_clear      = deliver && is_cpl && rx_cpl_last;
    end

    // Per-tag outstanding table: issue sets, final good completion clears, set wins.
    logic [NUM_TAGS-1:0] outstand_upd;
    logic [NUM_TAGS-1:0] kind_cfg_upd;
    logic [NUM_TAGS-1:0] kind_small_upd;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TAGS; gi++) begin : g_tag
            logic set_here;
            logic clr_here;
            assign set_here = req_issue && (32'(req_tag) == gi);
            assign clr_here = cpl_clear && (32'(rx_tag) == gi);
            assign outstand_upd[gi]   = set_here || (st_reg.outstand[gi] && !clr_here);
            assign kind_cfg_upd[gi]   = set_here ? req_to_cfg : st_reg.kind_cfg[gi];
            assign kind_small_upd[gi] = set_here ? (req_to_cfg || req_to_io)
                                                 : st_reg.kind_small[gi];
        end
    endgenerate

    // Next-state logic for registers, verdicts and error events.
    always_comb begin
        st_next            = st_reg;
        st_next.outstand   = outstand_upd;
        st_next.kind_cfg   = kind_cfg_upd;
        st_next.kind_small = kind_small_upd;
        st_next.rdata      = 32'h0000_0000;
        st_next.app_valid  = deliver;
        st_next.app_poison = deliver && rx_poison;
        st_next.cfg_update = deliver && is_cfg0 && has_data && !rx_poison;
        st_next.ur_valid   = rx_valid && unsupp && !posted && !is_cpl && !is_cpl_lock
                           && !rx_overflow && !rx_malformed;
        st_next.ur_req_id  = rx_req_id;
        st_next.ur_tag     = rx_tag;
        st_next.err_valid  = 1'b0;
        st_next.err_class  = ec_pkg::EC_CLASS_NONE;
        st_next.err_cause  = ec_pkg::EC_CAUSE_NONE;
        // Software writes: control, command, own identifier and tag limit.
        if (reg_wr) begin
            case (reg_addr)
                `EC_OFS_CTRL:    st_next.native_ep = reg_wdata[`EC_CTRL_NATIVE_BIT];
                `EC_OFS_COMMAND: st_next.mem_en    = reg_wdata[`EC_CMD_MEM_EN_BIT];
                `EC_OFS_OWN_ID:  st_next.own_id    = reg_wdata[15:0];
                `EC_OFS_TAG_CFG: st_next.tag_limit = reg_wdata[7:0];
                default:         st_next.rdata     = 32'h0000_0000;
            endcase
        end
        // Software reads: data stand one cycle after the strobe, unmapped reads give zero.
        if (reg_rd) begin
            case (reg_addr)
                `EC_OFS_CTRL:      st_next.rdata = {31'h0, st_reg.native_ep};
                `EC_OFS_COMMAND:   st_next.rdata = {30'h0, st_reg.mem_en, 1'h0};
                `EC_OFS_OWN_ID:    st_next.rdata = {16'h0, st_reg.own_id};
                `EC_OFS_TAG_CFG:   st_next.rdata = {24'h0, st_reg.tag_limit};
                `EC_OFS_ERR_COUNT: st_next.rdata = {16'h0, st_reg.fatal_count,
                                                    st_reg.nf_count};
                `EC_OFS_OUTSTAND:  st_next.rdata = 32'(st_reg.outstand);
                default:           st_next.rdata = 32'h0000_0000;
            endcase
        end
        // Application reports are held until an event slot is free; a new report wins.
        st_next.app_pend = st_reg.app_pend | {app_err[2], app_err[0]};
        // Received packet errors in priority order, then held application reports.
        if (rx_valid && rx_overflow) begin
            st_next.err_valid = 1'b1;
            st_next.err_class = ec_pkg::EC_CLASS_FATAL;
            st_next.err_cause = ec_pkg::EC_CAUSE_OVERFLOW;
        end else if (rx_valid && rx_malformed) begin
            st_next.err_valid = 1'b1;
            st_next.err_class = ec_pkg::EC_CLASS_FATAL;
            st_next.err_cause = ec_pkg::EC_CAUSE_MALFORMED;
        end else if (rx_valid && unsupp) begin
            st_next.err_valid = 1'b1;
            st_next.err_class = ec_pkg::EC_CLASS_NONFATAL;
            st_next.err_cause = ec_pkg::EC_CAUSE_UNSUPP;
        end else if (rx_valid && unexp_cpl) begin
            st_next.err_valid = 1'b1;
            st_next.err_class = ec_pkg::EC_CLASS_NONFATAL;
            st_next.err_cause = ec_pkg::EC_CAUSE_UNEXP_CPL;
        end else if (rx_valid && rx_poison) begin
            st_next.err_valid = 1'b1;
            st_next.err_class = ec_pkg::EC_CLASS_NONFATAL;
            st_next.err_cause = ec_pkg::EC_CAUSE_POISON;
        end else if (st_reg.app_pend[0]) begin
            st_next.err_valid   = 1'b1;
            st_next.err_class   = ec_pkg::EC_CLASS_NONFATAL;
            st_next.err_cause   = ec_pkg::EC_CAUSE_TIMEOUT;
            st_next.app_pend[0] = app_err[0];
        end else if (st_reg.app_pend[1]) begin
            st_next.err_valid   = 1'b1;
            st_next.err_class   = ec_pkg::EC_CLASS_NONFATAL;
            st_next.err_cause   = ec_pkg::EC_CAUSE_ABORT;
            st_next.app_pend[1] = app_err[2];
        end
        // Event counters by class, wrapping.
        if (st_next.err_valid && st_next.err_class == ec_pkg::EC_CLASS_FATAL) begin
            st_next.fatal_count = st_reg.fatal_count + 8'h01;
        end else if (st_next.err_valid) begin
            st_next.nf_count = st_reg.nf_count + 8'h01;
        end
    end

    // State register.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_reg           <= '0;
            st_reg.native_ep <= `EC_CTRL_RESET;
            st_reg.mem_en    <= `EC_MEM_EN_RESET;
            st_reg.own_id    <= `EC_OWN_ID_RESET;
            st_reg.tag_limit <= `EC_TAG_LIMIT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state register.
    assign reg_rdata     = st_reg.rdata;
    assign app_valid     = st_reg.app_valid;
    assign app_poison    = st_reg.app_poison;
    assign cfg_update    = st_reg.cfg_update;
    assign ur_cpl_valid  = st_reg.ur_valid;
    assign ur_cpl_req_id = st_reg.ur_req_id;
    assign ur_cpl_tag    = st_reg.ur_tag;
    assign err_valid     = st_reg.err_valid;
    assign err_class     = st_reg.err_class;
    assign err_cause     = st_reg.err_cause;

    // Checks on the verdicts one cycle after the header, on application reports and on every error event.
    a_poison_forward: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && rx_poison && !dropped |=> app_valid && app_poison
            && err_cause == ec_pkg::EC_CAUSE_POISON)
        else $error("Poisoned packet not forwarded and flagged.");

    a_type1_unsupp: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && is_cfg1 && !rx_overflow && !rx_malformed
            |=> !app_valid && ur_cpl_valid && err_cause == ec_pkg::EC_CAUSE_UNSUPP)
        else $error("Type 1 configuration request not refused.");

    a_mem_disabled: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && is_mem && !st_reg.mem_en |=> !app_valid && !cfg_update)
        else $error("Memory request delivered while memory space disabled.");

    a_ur_cpl_ids: assert property (@(posedge clk_sys) disable iff (reset)
        ur_cpl_valid |-> ur_cpl_req_id == $past(rx_req_id) && ur_cpl_tag == $past(rx_tag)
            && $past(rx_valid) && !$past(posted))
        else $error("UR completion without a matching non-posted request.");

    a_unexp_drop: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && is_cpl && !unsupp && !rx_overflow && !rx_malformed
            && rx_req_id != st_reg.own_id
            |=> !app_valid && err_valid && err_class == ec_pkg::EC_CLASS_NONFATAL)
        else $error("Unexpected completion delivered or not flagged.");

    a_stray_tag: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && is_cpl && tag_in_range && !st_reg.outstand[rx_tag[$clog2(NUM_TAGS)-1:0]]
            |=> !app_valid)
        else $error("Completion for a tag not outstanding delivered.");

    a_overflow_fatal: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && rx_overflow |=> err_valid && err_class == ec_pkg::EC_CLASS_FATAL
            && !app_valid && !ur_cpl_valid)
        else $error("Receiver overflow not fatal or not dropped.");

    a_poison_cfg_wr: assert property (@(posedge clk_sys) disable iff (reset)
        cfg_update |-> !$past(rx_poison) && $past(is_cfg0) && $past(has_data))
        else $error("Configuration updated from a poisoned write.");

    a_timeout_bound: assert property (@(posedge clk_sys) disable iff (reset)
        app_err[0] |=> ##1 err_valid)
        else $error("Completion timeout report not turned into an event.");

    a_abort_logged: assert property (@(posedge clk_sys) disable iff (reset)
        app_err[2] && !app_err[0] && !st_reg.app_pend[0]
            ##1 !(rx_valid && (dropped || rx_poison)) |=> err_cause == ec_pkg::EC_CAUSE_ABORT)
        else $error("Completer abort report not logged as abort.");

    a_event_pulse: assert property (@(posedge clk_sys) disable iff (reset)
        err_valid |-> err_class != ec_pkg::EC_CLASS_NONE && err_cause != ec_pkg::EC_CAUSE_NONE)
        else $error("Error event without class or cause.");

    a_cfg0_nofunc: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && is_cfg0 && !rx_func_exists && !rx_overflow && !rx_malformed
            |=> !app_valid && ur_cpl_valid && err_cause == ec_pkg::EC_CAUSE_UNSUPP)
        else $error("Missing function not refused.");

    a_native_lock: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && is_mem_lock_rd && st_reg.native_ep && !rx_overflow && !rx_malformed
            |=> !app_valid && ur_cpl_valid)
        else $error("Locked read accepted.");

    a_lock_cpl_ur: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && is_cpl_lock && rx_addr_hi_zero |=> !app_valid && !ur_cpl_valid && err_valid)
        else $error("Locked completion not refused.");

    a_no_window: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && (is_mem || is_io) && !rx_bar_hit |=> !app_valid && err_valid)
        else $error("Request outside windows delivered.");

    a_tag_range: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && is_cpl && !tag_in_range |=> !app_valid && err_valid)
        else $error("Invalid tag delivered.");

    a_long_cpl: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && is_cpl && st_reg.kind_small[rx_tag[$clog2(NUM_TAGS)-1:0]]
            && rx_length != `EC_CPL_SMALL_LEN |=> !app_valid && err_valid)
        else $error("Long small completion delivered.");

    a_crs_cpl: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && is_cpl && rx_cpl_status == `EC_CPL_STATUS_CRS
            && !st_reg.kind_cfg[rx_tag[$clog2(NUM_TAGS)-1:0]] |=> !app_valid && err_valid)
        else $error("Stray retry status delivered.");

    a_malformed_drop: assert property (@(posedge clk_sys) disable iff (reset)
        rx_valid && rx_malformed |=> !app_valid && err_class == ec_pkg::EC_CLASS_FATAL)
        else $error("Malformed packet not dropped.");

    // Main scenarios.
    c_ur_completion: cover property (@(posedge clk_sys) disable iff (reset) ur_cpl_valid);
    c_poison_deliver: cover property (@(posedge clk_sys) disable iff (reset) app_poison);
    c_unexp_cpl: cover property (@(posedge clk_sys) disable iff (reset)
        err_cause == ec_pkg::EC_CAUSE_UNEXP_CPL);
    c_issue_then_cpl: cover property (@(posedge clk_sys) disable iff (reset)
        req_issue ##[1:20] (rx_valid && is_cpl && deliver));

endmodule // ec_rx_error_checker

// File: rtl/ec_params.svh
// Purpose: Offsets, field positions, reset values and TLP codes of the receive error checker.
// Assumes: Included by the checker module and by any bench that drives its register port.
// Notes:   Definitions only.
`ifndef EC_PARAMS_SVH
`define EC_PARAMS_SVH

// Register offsets on the plain register port.
`define EC_OFS_CTRL        8'h00
`define EC_OFS_COMMAND     8'h04
`define EC_OFS_OWN_ID      8'h08
`define EC_OFS_TAG_CFG     8'h0c
`define EC_OFS_ERR_COUNT   8'h10
`define EC_OFS_OUTSTAND    8'h14

// Field positions.
`define EC_CTRL_NATIVE_BIT 0
`define EC_CMD_MEM_EN_BIT  1

// Reset values.
`define EC_CTRL_RESET      1'h1
`define EC_MEM_EN_RESET    1'h0
`define EC_OWN_ID_RESET    16'h0000
`define EC_TAG_LIMIT_RESET 8'h20

// TLP type field codes.
`define EC_TYPE_MEM        5'h00
`define EC_TYPE_MEM_LOCK   5'h01
`define EC_TYPE_IO         5'h02
`define EC_TYPE_CFG0       5'h04
`define EC_TYPE_CFG1       5'h05
`define EC_TYPE_CPL        5'h0a
`define EC_TYPE_CPL_LOCK   5'h0b
`define EC_MSG_PREFIX      2'h2

// Completion status code for configuration retry.
`define EC_CPL_STATUS_CRS  3'h2
// Only completion length accepted for an I/O or configuration request, in dwords.
`define EC_CPL_SMALL_LEN   10'h001

`endif

// File: rtl/ec_pkg.sv
// Purpose: Types shared by the receive error checker and its bench.
// Assumes: Nothing beyond the standard language.
// Notes:   Enumerations only; numeric constants live in ec_params.svh.
package ec_pkg;

    // Severity class reported with every error event.
    typedef enum logic [1:0] {
        EC_CLASS_NONE      = 2'h0,
        EC_CLASS_CORRECT   = 2'h1,
        EC_CLASS_NONFATAL  = 2'h2,
        EC_CLASS_FATAL     = 2'h3
    } ec_class_e;

    // Cause reported with every error event.
    typedef enum logic [2:0] {
        EC_CAUSE_NONE      = 3'h0,
        EC_CAUSE_POISON    = 3'h1,
        EC_CAUSE_UNSUPP    = 3'h2,
        EC_CAUSE_UNEXP_CPL = 3'h3,
        EC_CAUSE_TIMEOUT   = 3'h4,
        EC_CAUSE_ABORT     = 3'h5,
        EC_CAUSE_OVERFLOW  = 3'h6,
        EC_CAUSE_MALFORMED = 3'h7
    } ec_cause_e;

endpackage

// File: testbench/ec_app_model.sv
// Purpose: Application-side partner that issues requests, times them and reports errors.
// Assumes: The bench asks for requests and aborts on clk_sys; watches delivered packets.
// Notes:   Times only the latest request; any delivery stops the timer.
`timescale 1ns/10ps

module ec_app_model #(
    parameter int TMO = 50
) (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       go_issue,
    input  wire logic [7:0] go_tag,
    input  wire logic       go_cfg,
    input  wire logic       go_abort,
    input  wire logic       app_valid,
    input  wire logic       app_poison,
    output logic            req_issue,
    output logic      [7:0] req_tag,
    output logic            req_to_cfg,
    output logic            req_to_io,
    output logic      [2:0] app_err,
    output logic      [7:0] poison_cnt
);
    int tmr;

    // This application never issues I/O requests.
    assign req_to_io = 1'b0;

    // Request launch, completion timer, error reports and poisoned delivery count.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            {req_issue, req_tag, req_to_cfg, app_err, poison_cnt} <= '0;
            tmr <= 0;
        end else begin
            {req_issue, req_tag, req_to_cfg} <= {go_issue, go_tag, go_cfg};
            app_err <= {go_abort, 1'b0, tmr == TMO};
            if (go_issue) begin
                tmr <= 1;
            end else if (app_valid || tmr == TMO || tmr == 0) begin
                tmr <= 0;
            end else begin
                tmr <= tmr + 1;
            end
            if (app_valid && app_poison) begin
                poison_cnt <= poison_cnt + 8'h01;
            end
        end
    end
endmodule // ec_app_model

// File: testbench/ec_rx_error_checker_tb.sv
// Purpose: Self-checking bench for the receive error checker.
// Assumes: Inputs change by non-blocking assignment at the rising edge of clk_sys.
// Notes:   Expected verdicts follow the per-header priority of the checker.
`timescale 1ns/10ps
`include "ec_params.svh"

module ec_rx_error_checker_tb;
    localparam logic [7:0] K_PSN = 8'h80, K_HI0 = 8'h40, K_BAR = 8'h20, K_FN = 8'h10;
    localparam logic [7:0] K_MSG = 8'h08, K_OVF = 8'h04, K_MAL = 8'h02, K_LST = 8'h01;
    logic        clk_sys = 1'b0, reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00, rx_tag = 8'h00, go_tag = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, rx_valid = 1'b0;
    logic [2:0]  rx_fmt = 3'h0, rx_cpl_status = 3'h0, app_err;
    logic [4:0]  rx_type = 5'h00;
    logic [15:0] rx_req_id = 16'h0, ur_cpl_req_id;
    logic [7:0]  ur_cpl_tag, req_tag, poison_cnt;
    logic [9:0]  rx_length = 10'h000;
    logic        rx_poison = 1'b0, rx_addr_hi_zero = 1'b0, rx_bar_hit = 1'b0;
    logic        rx_func_exists = 1'b0, rx_msg_known = 1'b0, rx_overflow = 1'b0;
    logic        rx_malformed = 1'b0, rx_cpl_last = 1'b0;
    logic        go_issue = 1'b0, go_cfg = 1'b0, go_abort = 1'b0;
    logic        req_issue, req_to_cfg, req_to_io, app_valid, app_poison, cfg_update;
    logic        ur_cpl_valid, err_valid, cu, ap;
    ec_pkg::ec_class_e err_class;
    ec_pkg::ec_cause_e err_cause;
    int          miscompares = 0, checks_done = 0, nf = 0, ft = 0;

    // Clock at 40 MHz.
    always #12.5 clk_sys = ~clk_sys;

    ec_rx_error_checker #(.NUM_TAGS(32)) i_dut (.*);
    ec_app_model #(.TMO(50)) i_app (.*);

    // Comparison, register access, header and request tasks.
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, e);
    endtask

    task automatic hdr(input logic [2:0] fm, input logic [4:0] ty, input logic [7:0] fl,
                       input logic [7:0] tg, input logic [9:0] ln, input logic [2:0] st,
                       input logic [15:0] id, input logic ea, eu, input logic [2:0] ec);
        @(posedge clk_sys);
        {rx_valid, rx_fmt, rx_type, rx_tag, rx_length} <= {1'b1, fm, ty, tg, ln};
        {rx_cpl_status, rx_req_id} <= {st, id};
        {rx_poison, rx_addr_hi_zero, rx_bar_hit, rx_func_exists} <= fl[7:4];
        {rx_msg_known, rx_overflow, rx_malformed, rx_cpl_last} <= fl[3:0];
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        #1 cu = cfg_update;
        ap = app_poison;
        chk("app_valid", app_valid, ea);
        chk("ur_cpl_valid", ur_cpl_valid, eu);
        if (eu) chk("ur_cpl_id_tag", {ur_cpl_req_id, ur_cpl_tag}, {id, tg});
        chk("err_valid", err_valid, ec != 3'h0);
        if (ec != 3'h0) chk("err_cause", err_cause, ec);
        if (ec != 3'h0) chk("err_class", err_class, (ec >= 3'h6) ? 2'h3 : 2'h2);
        if (ec >= 3'h6) ft++;
        else if (ec != 3'h0) nf++;
    endtask

    task automatic issue(input logic [7:0] tg, input logic cf);
        @(posedge clk_sys);
        {go_issue, go_tag, go_cfg} <= {1'b1, tg, cf};
        @(posedge clk_sys);
        go_issue <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic wait_ev(input logic [2:0] ec);
        int n;
        n = 0;
        #1;
        while (err_valid !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk("err_cause", err_cause, ec);
        chk("err_class", err_class, 2'h2);
        nf++;
        if (n >= 400) begin
            tally_and_finish();
        end else begin
            @(posedge clk_sys);
            #1 chk("err_valid", err_valid, 1'b0);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Main sequence: reset, register defaults, then each class of header.
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rd(`EC_OFS_CTRL, 32'h1);
        rd(`EC_OFS_COMMAND, 32'h0);
        rd(`EC_OFS_TAG_CFG, 32'h20);
        rd(8'h40, 32'h0);
        @(posedge clk_sys);
        #1 chk("reg_rdata_idle", reg_rdata, 32'h0);
        hdr(3'h0, `EC_TYPE_CFG1, K_FN, 8'h11, 10'h1, 3'h0, 16'h0203, 0, 1, 2);
        hdr(3'h0, `EC_TYPE_CFG0, 8'h00, 8'h12, 10'h1, 3'h0, 16'h0204, 0, 1, 2);
        hdr(3'h1, 5'h10, 8'h00, 8'h00, 10'h0, 3'h0, 16'h0, 0, 0, 2);
        hdr(3'h0, `EC_TYPE_MEM, K_BAR, 8'h01, 10'h1, 3'h0, 16'h0, 0, 1, 2);
        wr(`EC_OFS_COMMAND, 32'h2);
        rd(`EC_OFS_COMMAND, 32'h2);
        hdr(3'h0, `EC_TYPE_MEM, K_BAR, 8'h02, 10'h1, 3'h0, 16'h0, 1, 0, 0);
        hdr(3'h0, `EC_TYPE_MEM, 8'h00, 8'h03, 10'h1, 3'h0, 16'h0, 0, 1, 2);
        hdr(3'h2, `EC_TYPE_MEM, 8'h00, 8'h00, 10'h1, 3'h0, 16'h0, 0, 0, 2);
        hdr(3'h0, `EC_TYPE_IO, 8'h00, 8'h04, 10'h1, 3'h0, 16'h0, 0, 1, 2);
        hdr(3'h0, `EC_TYPE_MEM_LOCK, K_BAR, 8'h05, 10'h1, 3'h0, 16'h0, 0, 1, 2);
        wr(`EC_OFS_CTRL, 32'h0);
        hdr(3'h0, `EC_TYPE_MEM_LOCK, K_BAR, 8'h06, 10'h1, 3'h0, 16'h0, 1, 0, 0);
        hdr(3'h2, `EC_TYPE_MEM, K_PSN | K_BAR, 8'h00, 10'h1, 3'h0, 16'h0, 1, 0, 1);
        chk("app_poison", ap, 1'b1);
        hdr(3'h2, `EC_TYPE_CFG0, K_PSN | K_FN, 8'h07, 10'h1, 3'h0, 16'h0, 0, 1, 2);
        chk("cfg_update", cu, 1'b0);
        hdr(3'h2, `EC_TYPE_CFG0, K_FN, 8'h08, 10'h1, 3'h0, 16'h0, 1, 0, 0);
        chk("cfg_update", cu, 1'b1);
        hdr(3'h0, `EC_TYPE_CPL_LOCK, K_HI0 | K_LST, 8'h00, 10'h1, 3'h0, 16'h0, 0, 0, 2);
        wr(`EC_OFS_OWN_ID, 32'h0100);
        issue(8'h03, 1'b1);
        hdr(3'h2, `EC_TYPE_CPL, K_LST, 8'h03, 10'h1, 3'h0, 16'h0100, 1, 0, 0);
        hdr(3'h2, `EC_TYPE_CPL, K_LST, 8'h03, 10'h1, 3'h0, 16'h0100, 0, 0, 3);
        issue(8'h03, 1'b1);
        hdr(3'h2, `EC_TYPE_CPL, K_LST, 8'h03, 10'h1, 3'h0, 16'h0200, 0, 0, 3);
        issue(8'h05, 1'b1);
        hdr(3'h2, `EC_TYPE_CPL, K_LST, 8'h05, 10'h2, 3'h0, 16'h0100, 0, 0, 3);
        issue(8'h06, 1'b0);
        hdr(3'h0, `EC_TYPE_CPL, K_LST, 8'h06, 10'h0, 3'h2, 16'h0100, 0, 0, 3);
        rd(`EC_OFS_OUTSTAND, 32'h68);
        issue(8'h10, 1'b1);
        wr(`EC_OFS_TAG_CFG, 32'h10);
        hdr(3'h2, `EC_TYPE_CPL, K_LST, 8'h10, 10'h1, 3'h0, 16'h0100, 0, 0, 3);
        hdr(3'h2, `EC_TYPE_MEM, K_BAR | K_OVF, 8'h00, 10'h1, 3'h0, 16'h0, 0, 0, 6);
        hdr(3'h2, `EC_TYPE_MEM, K_BAR | K_MAL, 8'h00, 10'h1, 3'h0, 16'h0, 0, 0, 7);
        issue(8'h07, 1'b0);
        wait_ev(3'h4);
        @(posedge clk_sys);
        go_abort <= 1'b1;
        @(posedge clk_sys);
        go_abort <= 1'b0;
        wait_ev(3'h5);
        rd(`EC_OFS_ERR_COUNT, {16'h0, ft[7:0], nf[7:0]});
        chk("poison_cnt", poison_cnt, 8'h01);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        rd(`EC_OFS_OUTSTAND, 32'h0);
        rd(`EC_OFS_TAG_CFG, 32'h20);
        tally_and_finish();
    end
endmodule // ec_rx_error_checker_tb
